/* design/lhb_host_bus.sv */
// module: host bus interface, parallel 8080/6800 and serial write-only link
module lhb_host_bus
    import lhb_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       serClk,
    input  wire logic       resetNInput,
    input  wire logic       csN,
    input  wire logic       cmdDataSelect,
    input  wire logic       rdN,
    input  wire logic       wrN,
    input  wire logic       busStyleSelect,
    input  wire logic       parSerSelect,
    input  wire logic [7:0] dataIn,
    output lhb_pins_s       pinsOut,
    output lhb_byte_s       rxByte,
    output logic            rxValid,
    output logic            initActive,
    input  wire logic [7:0] readData
);

    //------------------------------------------------------------------
    // serial domain: shift register on the host shift clock
    //------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] shift;
        logic [2:0] bitCnt;
        logic [7:0] word;
        logic       isDisplay;
        logic       tog;
    } lhb_ser_s;

    lhb_ser_s serReg;
    lhb_ser_s serNext;
    lhb_ser_s serHoldReg;
    logic     serRst;

    // partial byte clears while deselected, in parallel mode or while the reset pin is low
    assign serRst = rst | csN | ~resetNInput | parSerSelect;         // see (R7) (R14)

    always_comb begin
        serNext           = serReg;
        serNext.word      = serHoldReg.word;
        serNext.isDisplay = serHoldReg.isDisplay;
        serNext.tog       = serHoldReg.tog;
        serNext.shift  = {serReg.shift[6:0], dataIn[SER_DATA_BIT]};   // see (R2) (R16)
        serNext.bitCnt = serReg.bitCnt + 3'h1;
        if (serReg.bitCnt == BITCNT_LAST) begin                       // see (R16)
            serNext.word      = {serReg.shift[6:0], dataIn[SER_DATA_BIT]};
            serNext.isDisplay = cmdDataSelect;                         // see (R6)
            serNext.tog       = ~serReg.tog;
        end
    end

    // shift state: a deselect cuts the byte so it never completes
    always_ff @(posedge serClk or posedge serRst) begin
        if (serRst) begin
            serReg <= '{shift: DATA_RST, bitCnt: BITCNT_RST, word: DATA_RST,
                        isDisplay: 1'b0, tog: 1'b0};
        end else begin
            serReg <= serNext;
        end
    end

    // finished byte and toggle survive deselect, so the crossing sees no false edge
    always_ff @(posedge serClk or posedge rst) begin
        if (rst) begin
            serHoldReg <= '{shift: DATA_RST, bitCnt: BITCNT_RST, word: DATA_RST,
                            isDisplay: 1'b0, tog: 1'b0};
        end else begin
            serHoldReg <= serNext;
        end
    end

    //------------------------------------------------------------------
    // serial domain checks
    //------------------------------------------------------------------
    chk_serial_count: assert property (@(posedge serClk) disable iff (serRst) // see (R16)
        serReg.bitCnt == BITCNT_LAST |=> serHoldReg.tog != $past(serHoldReg.tog))
        else $error("serial byte not handed over after eight bits");

    chk_serial_lsb: assert property (@(posedge serClk) disable iff (serRst) // see (R16)
        serReg.bitCnt == BITCNT_LAST |=> serHoldReg.word[0] == $past(dataIn[SER_DATA_BIT]))
        else $error("last serial bit not in lsb");

    chk_serial_hold: assert property (@(posedge serClk) disable iff (serRst) // see (R16)
        serReg.bitCnt != BITCNT_LAST |=> serHoldReg.tog == $past(serHoldReg.tog))
        else $error("serial byte handed over early");

    //------------------------------------------------------------------
    // main domain state
    //------------------------------------------------------------------
    typedef enum logic [1:0] {ST_INIT, ST_RUN} lhb_state_e;

    typedef struct packed {
        lhb_state_e state;
        logic [1:0] psSync;
        logic [1:0] styleSync;
        logic [1:0] csSync;
        logic [1:0] rdSync;
        logic [1:0] wrSync;
        logic [1:0] resSync;
        logic [1:0] cdSync;
        logic [2:0] togSync;
        logic [7:0] dataS1;
        logic [7:0] dataS2;
        logic       strobePrev;
        lhb_pins_s  pins;
        lhb_byte_s  rx;
        logic       valid;
        logic       init;
    } lhb_main_s;

    lhb_main_s mainReg;
    lhb_main_s mainNext;

    logic      serWordTog;
    logic      serWordDisp;
    logic [7:0] serWordVal;
    assign serWordTog  = serHoldReg.tog;
    assign serWordDisp = serHoldReg.isDisplay;
    assign serWordVal  = serHoldReg.word;

    logic       parMode;
    logic       style68;
    logic       selected;
    logic       readDrive;
    logic       strobeNow;
    logic       isWrite;

    // two-stage synchroniser step: the first stage is read only by the second
    function automatic logic [1:0] sync2(input logic [1:0] stages, input logic pin);
        return {stages[0], pin};
    endfunction : sync2

    always_comb begin
        mainNext = mainReg;
        mainNext.psSync    = sync2(mainReg.psSync, parSerSelect);
        mainNext.styleSync = sync2(mainReg.styleSync, busStyleSelect);
        mainNext.csSync    = sync2(mainReg.csSync, csN);
        mainNext.rdSync    = sync2(mainReg.rdSync, rdN);
        mainNext.wrSync    = sync2(mainReg.wrSync, wrN);
        mainNext.resSync   = sync2(mainReg.resSync, resetNInput);
        mainNext.cdSync    = sync2(mainReg.cdSync, cmdDataSelect);
        mainNext.togSync   = {mainReg.togSync[1:0], serWordTog};
        mainNext.dataS1    = dataIn;
        mainNext.dataS2    = mainReg.dataS1;
        mainNext.valid     = 1'b0;

        parMode  = mainReg.psSync[1];                                  // see (R14)
        style68  = mainReg.styleSync[1];                               // see (R13)
        selected = ~mainReg.csSync[1];                                 // see (R7)
        // 6800: enable high qualifies, write pin high means read
        isWrite   = style68 ? ~mainReg.wrSync[1] : 1'b1;              // see (R12)
        strobeNow = style68 ? mainReg.rdSync[1] : ~mainReg.wrSync[1]; // see (R11)
        readDrive = parMode & selected &
                    (style68 ? (mainReg.rdSync[1] & mainReg.wrSync[1])  // see (R11) (R12)
                             : ~mainReg.rdSync[1]);                       // see (R9)

        case (mainReg.state)
            ST_INIT: begin
                mainNext.init = 1'b1;
                if (mainReg.resSync[1]) begin
                    mainNext.state = ST_RUN;
                    mainNext.init  = 1'b0;
                end
            end
            ST_RUN: begin
                mainNext.init = 1'b0;
                if (parMode) begin
                    // write taken on the trailing edge of the strobe
                    if (selected && mainReg.strobePrev && !strobeNow && isWrite) begin // see (R10)
                        mainNext.rx.value     = mainReg.dataS2;                        // see (R1)
                        mainNext.rx.isDisplay = mainReg.cdSync[1];                     // see (R6)
                        mainNext.valid        = 1'b1;
                    end
                end else if (mainReg.togSync[2] != mainReg.togSync[1]) begin          // see (R4)
                    mainNext.rx.value     = serWordVal;
                    mainNext.rx.isDisplay = serWordDisp;
                    mainNext.valid        = 1'b1;
                end
                if (!mainReg.resSync[1]) begin                                         // see (R8)
                    mainNext.state = ST_INIT;
                    mainNext.init  = 1'b1;
                    mainNext.valid = 1'b0;
                end
            end
            default: begin
                mainNext.state = ST_INIT;
            end
        endcase

        mainNext.strobePrev = strobeNow;
        // serial mode and deselect release every line; no read back in serial
        mainNext.pins.dataOut = readData;
        mainNext.pins.dataOe  = (readDrive && mainReg.state == ST_RUN)              // see (R9)
                                ? 8'h00 : 8'hFF;                                    // see (R3) (R5) (R15)
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mainReg <= '{state: ST_INIT, psSync: 2'h3, styleSync: 2'h0, csSync: 2'h3,
                         rdSync: 2'h3, wrSync: 2'h3, resSync: 2'h0, cdSync: 2'h0,
                         togSync: 3'h0, dataS1: DATA_RST, dataS2: DATA_RST,
                         strobePrev: 1'b0, pins: '{dataOut: DATA_RST, dataOe: 8'hFF},
                         rx: '{isDisplay: 1'b0, value: DATA_RST}, valid: 1'b0,
                         init: 1'b1};
        end else begin
            mainReg <= mainNext;
        end
    end

    assign pinsOut    = mainReg.pins;
    assign rxByte     = mainReg.rx;
    assign rxValid    = mainReg.valid;
    assign initActive = mainReg.init;

    //------------------------------------------------------------------
    // checks
    //------------------------------------------------------------------
    chk_deselect_release: assert property (@(posedge ref_clk) disable iff (rst) // see (R5)
        mainReg.csSync[1] |=> pinsOut.dataOe == 8'hFF)
        else $error("data lines driven while deselected");
    chk_serial_release: assert property (@(posedge ref_clk) disable iff (rst) // see (R3)
        !mainReg.psSync[1] |=> pinsOut.dataOe == 8'hFF)
        else $error("data lines driven in serial mode");
    chk_reset_level: assert property (@(posedge ref_clk) disable iff (rst) // see (R8)
        !mainReg.resSync[1] |=> initActive && !rxValid)
        else $error("init not held while reset low");
    chk_read_drive: assert property (@(posedge ref_clk) disable iff (rst) // see (R9)
        (mainReg.state == ST_RUN && mainReg.psSync[1] && !mainReg.csSync[1]
         && !mainReg.styleSync[1] && !mainReg.rdSync[1]) |=> pinsOut.dataOe == 8'h00)
        else $error("no drive during 8080 read");
    chk_write_capture: assert property (@(posedge ref_clk) disable iff (rst) // see (R10)
        (mainReg.state == ST_RUN && mainReg.resSync[1] && mainReg.psSync[1]
         && !mainReg.csSync[1] && !mainReg.styleSync[1]
         && mainReg.strobePrev && mainReg.wrSync[1]) |=> rxValid && rxByte.value == $past(mainReg.dataS2))
        else $error("8080 write not captured");
    chk_flag_select: assert property (@(posedge ref_clk) disable iff (rst) // see (R6)
        (rxValid && $past(mainReg.psSync[1])) |-> rxByte.isDisplay == $past(mainReg.cdSync[1]))
        else $error("byte kind wrong");
    chk_no_select: assert property (@(posedge ref_clk) disable iff (rst) // see (R7)
        ($past(mainReg.csSync[1]) && $past(mainReg.psSync[1])) |-> !rxValid)
        else $error("byte taken while deselected");
    chk_e_read: assert property (@(posedge ref_clk) disable iff (rst) // see (R11)
        (mainReg.state == ST_RUN && mainReg.psSync[1] && !mainReg.csSync[1]
         && mainReg.styleSync[1] && mainReg.rdSync[1] && mainReg.wrSync[1])
        |=> pinsOut.dataOe == 8'h00)
        else $error("no drive during 6800 read");

    chk_e_write: assert property (@(posedge ref_clk) disable iff (rst) // see (R11) (R12)
        (mainReg.state == ST_RUN && mainReg.resSync[1] && mainReg.psSync[1]
         && !mainReg.csSync[1] && mainReg.styleSync[1] && mainReg.strobePrev
         && !mainReg.rdSync[1] && !mainReg.wrSync[1]) |=> rxValid)
        else $error("6800 write not captured");

    chk_dir_read: assert property (@(posedge ref_clk) disable iff (rst) // see (R12)
        (mainReg.psSync[1] && mainReg.styleSync[1] && mainReg.wrSync[1]) |=> !rxValid)
        else $error("byte taken during 6800 read");

    chk_e_low_quiet: assert property (@(posedge ref_clk) disable iff (rst) // see (R13)
        (mainReg.psSync[1] && mainReg.styleSync[1] && !mainReg.rdSync[1])
        |=> pinsOut.dataOe == 8'hFF)
        else $error("drive while 6800 enable low");

    chk_rd_high_quiet: assert property (@(posedge ref_clk) disable iff (rst) // see (R9)
        (mainReg.psSync[1] && !mainReg.styleSync[1] && mainReg.rdSync[1])
        |=> pinsOut.dataOe == 8'hFF)
        else $error("drive while 8080 read strobe high");

    chk_read_value: assert property (@(posedge ref_clk) disable iff (rst) // see (R1)
        readDrive |=> pinsOut.dataOut == $past(readData))
        else $error("read value not presented");

    chk_serial_quiet: assert property (@(posedge ref_clk) disable iff (rst) // see (R4)
        (!mainReg.psSync[1] && mainReg.togSync[2] == mainReg.togSync[1]) |=> !rxValid)
        else $error("serial byte without handover");

    chk_serial_kind: assert property (@(posedge ref_clk) disable iff (rst) // see (R6) (R16)
        (mainReg.state == ST_RUN && mainReg.resSync[1] && !mainReg.psSync[1]
         && mainReg.togSync[2] != mainReg.togSync[1])
        |=> rxValid && rxByte.isDisplay == $past(serWordDisp)
            && rxByte.value == $past(serWordVal))
        else $error("serial byte lost or wrong");

    chk_init_quiet: assert property (@(posedge ref_clk) disable iff (rst) // see (R8)
        mainReg.state == ST_INIT |=> !rxValid)
        else $error("byte taken during init");

    chk_init_leave: assert property (@(posedge ref_clk) disable iff (rst) // see (R8)
        (mainReg.state == ST_INIT && mainReg.resSync[1]) |=> !initActive)
        else $error("init not left after reset pin high");

endmodule : lhb_host_bus

/* design/lhb_pkg.sv */
// package: constants and carriers of the lcd host bus interface
//----------------------------------------------------------------------
// Summary of operation
//----------------------------------------------------------------------
// Summary of operation
// (R1) Eight-bit two-way data port carries command and display bytes in parallel mode.
// (R2) Serial mode: data arrives on bit 7, shift clock on bit 6.
// (R3) Serial mode: data bits 0 to 5 are never driven.
// (R4) Serial mode: ignore bits 0 to 5, read, write and bus-style pins.
// (R5) Chip select inactive: all eight data lines are released.
// (R6) Command/data select high means display data, low means control data.
// (R7) Bus input is taken only while chip select is low.
// (R8) Reset pin low holds the block in initialisation, by level.
// (R9) 8080 style: drive the data bus while the read strobe is low.
// (R10) 8080 style: latch data on the rising edge of the write strobe.
// (R11) 6800 style: read pin is an active-high enable clock qualifying transfers.
// (R12) 6800 style: write pin gives direction, high reads, low writes.
// (R13) Bus-style select high picks 6800 timing, low picks 8080 timing.
// (R14) Parallel/serial select high picks parallel, low picks serial input.
// (R15) Serial mode is write only; nothing is read back.
// (R16) Serial bits shift in msb first on rising clock, eight per byte.
package lhb_pkg;

    localparam int         DATA_W       = 8;
    localparam int         SER_DATA_BIT = 7;
    localparam int         SER_CLK_BIT  = 6;
    localparam logic [7:0] DATA_RST     = 8'h00;
    localparam logic [2:0] BITCNT_RST   = 3'h0;
    localparam logic [2:0] BITCNT_LAST  = 3'h7;

    typedef struct packed {
        logic       isDisplay;
        logic [7:0] value;
    } lhb_byte_s;

    typedef struct packed {
        logic [7:0] dataOut;
        logic [7:0] dataOe;
    } lhb_pins_s;

endpackage : lhb_pkg

/* verif/lhb_host_model.sv */
// host-side microprocessor model driving the lcd host bus pins
module lhb_host_model (
    input  wire logic       ref_clk,
    output logic            csN,
    output logic            cmdDataSelect,
    output logic            rdN,
    output logic            wrN,
    output logic [7:0]      hostData,
    output logic            hostDrive
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        csN = 1'b1;
        cmdDataSelect = 1'b0;
        rdN = 1'b1;
        wrN = 1'b1;
        hostData = 8'h00;
        hostDrive = 1'b0;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc
    // strobes inactive for the given style, bus released
    task automatic idle(input logic sty);
        @(posedge ref_clk);
        csN <= 1'b1;
        rdN <= ~sty;
        wrN <= 1'b1;
        hostDrive <= 1'b0;
    endtask : idle
    // parallel write, sty high means 6800 style
    task automatic wr(input logic sty, input logic cs, input logic isDisp, input logic [7:0] v);
        @(posedge ref_clk);
        csN <= ~cs;
        cmdDataSelect <= isDisp;
        hostData <= v;
        hostDrive <= 1'b1;
        wrN <= 1'b0;
        cyc(4);
        if (sty) begin
            rdN <= 1'b1;
            cyc(4);
            rdN <= 1'b0;
        end else begin
            wrN <= 1'b1;
        end
        cyc(4);
        idle(sty);
    endtask : wr
    task automatic rd(input logic sty, input logic cs);
        @(posedge ref_clk);
        csN <= ~cs;
        hostDrive <= 1'b0;
        rdN <= sty;
    endtask : rd
    // one serial byte on a 48 ns shift clock; strobe pin wiggles as noise
    task automatic ser(input logic isDisp, input logic [7:0] v);
        @(posedge ref_clk);
        csN <= 1'b0;
        cmdDataSelect <= isDisp;
        hostDrive <= 1'b1;
        hostData <= 8'h15;
        #7;
        for (int i = 7; i >= 0; i--) begin
            hostData[7] <= v[i];
            rdN <= v[i];
            #24 hostData[6] <= 1'b1;
            #24 hostData[6] <= 1'b0;
        end
        cyc(8);
    endtask : ser
endmodule : lhb_host_model

/* verif/lhb_host_bus_bench.sv */
// self-checking bench of the lcd host bus interface
module lhb_host_bus_bench
    import lhb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       ref_clk;
    logic       rst;
    logic       resetNInput;
    logic       busStyleSelect;
    logic       parSerSelect;
    logic [7:0] readData;
    logic [7:0] idlePat;
    logic [7:0] bus;
    logic       csN, cmdDataSelect, rdN, wrN, hostDrive, rxValid, initActive;
    logic [7:0] hostData;
    lhb_pins_s  pinsOut;
    lhb_byte_s  rxByte, gotByte;
    int         gotCnt = 0;
    int         err_count = 0;
    int         total_checks = 0;
    // released lines show the host data while it drives, else a pattern that flips every cycle
    assign bus = (~pinsOut.dataOe & pinsOut.dataOut) |
                 (pinsOut.dataOe & (hostDrive ? hostData : idlePat));
    lhb_host_bus dut (.ref_clk(ref_clk), .rst(rst), .serClk(bus[6]), .resetNInput(resetNInput),
        .csN(csN), .cmdDataSelect(cmdDataSelect), .rdN(rdN), .wrN(wrN),
        .busStyleSelect(busStyleSelect), .parSerSelect(parSerSelect), .dataIn(bus),
        .pinsOut(pinsOut), .rxByte(rxByte), .rxValid(rxValid), .initActive(initActive),
        .readData(readData));
    lhb_host_model host (.ref_clk(ref_clk), .csN(csN), .cmdDataSelect(cmdDataSelect),
        .rdN(rdN), .wrN(wrN), .hostData(hostData), .hostDrive(hostDrive));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        idlePat <= ~idlePat;
        if (rxValid === 1'b1) begin
            gotCnt <= gotCnt + 1;
            gotByte <= rxByte;
        end
    end
    task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic got_one(input int n0, input lhb_byte_s exp);
        host.cyc(6);
        chk(9'(gotCnt - n0), 9'h001, "byte count");
        chk(gotByte, exp, "byte value");
    endtask : got_one
    task automatic t_reset();
        int n0;
        n0 = gotCnt;
        resetNInput <= 1'b0;
        host.cyc(5);
        chk({8'h00, initActive}, 9'h001, "init on");
        host.wr(1'b0, 1'b1, 1'b1, 8'h5A);
        resetNInput <= 1'b1;
        host.cyc(8);
        chk({8'h00, initActive}, 9'h000, "init off");
        chk(9'(gotCnt - n0), 9'h000, "byte in init");
        $display("test reset done");
    endtask : t_reset
    task automatic t_par();
        int n0;
        for (int s = 0; s < 2; s++) begin
            busStyleSelect <= s[0];
            host.idle(s[0]);
            for (int d = 0; d < 2; d++) begin
                n0 = gotCnt;
                host.wr(s[0], 1'b1, d[0], 8'hA3 ^ 8'(s * 16 + d));
                got_one(n0, {d[0], 8'hA3 ^ 8'(s * 16 + d)});
            end
            n0 = gotCnt;
            host.wr(s[0], 1'b0, 1'b1, 8'hFF);
            host.cyc(6);
            chk(9'(gotCnt - n0), 9'h000, "chip off write");
            readData <= 8'hC3 ^ 8'(s);
            host.rd(s[0], 1'b1);
            host.cyc(6);
            chk({1'b0, pinsOut.dataOe}, 9'h000, "read drive");
            chk({1'b0, bus}, {1'b0, 8'hC3 ^ 8'(s)}, "read data");
            host.idle(s[0]);
            host.rd(s[0], 1'b0);
            host.cyc(6);
            chk({1'b0, pinsOut.dataOe}, 9'h0FF, "chip off read");
            host.idle(s[0]);
        end
        $display("test parallel done");
    endtask : t_par
    task automatic t_ser();
        int n0;
        parSerSelect <= 1'b0;
        busStyleSelect <= 1'b0;
        for (int d = 0; d < 2; d++) begin
            n0 = gotCnt;
            host.ser(d[0], d ? 8'h6C : 8'h92);
            chk({1'b0, pinsOut.dataOe}, 9'h0FF, "serial drive");
            got_one(n0, {d[0], d ? 8'h6C : 8'h92});
        end
        host.rd(1'b0, 1'b1);
        host.cyc(6);
        chk({1'b0, pinsOut.dataOe}, 9'h0FF, "serial read");
        parSerSelect <= 1'b1;
        host.idle(1'b0);
        $display("test serial done");
    endtask : t_ser
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        rst            = 1'b1;
        resetNInput    = 1'b1;
        busStyleSelect = 1'b0;
        parSerSelect   = 1'b1;
        readData       = 8'h00;
        idlePat        = 8'h55;
        repeat (19) @(posedge ref_clk);
        chk({1'b0, pinsOut.dataOe}, 9'h0FF, "reset release");
        @(posedge ref_clk);
        rst <= 1'b0;
        host.cyc(10);
        t_reset();
        t_par();
        t_ser();
        report_and_stop();
    end
    initial begin
        #100us;
        err_count++;
        report_and_stop();
    end
endmodule : lhb_host_bus_bench
